// file: include/fpp_pkg.sv
// Constants, register map and pin-mode decoding for the five pin port.
package fpp_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PORT_W = 5;
  localparam int ANA_W = 4;
  localparam int TIMER_PIN = 4;

  // ----------------------------------------------------------------
  // Register indices and byte addresses (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_DATA_IDX = 8'h05;
  localparam logic [7:0] PIN_DIR_IDX = 8'h85;
  localparam logic [7:0] ANA_CFG_IDX = 8'h9f;
  localparam logic [ADDR_W-1:0] PORT_DATA_ADDR = {2'h0, PORT_DATA_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] PIN_DIR_ADDR = {2'h0, PIN_DIR_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] ANA_CFG_ADDR = {2'h0, ANA_CFG_IDX, 2'h0};

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PORT_W-1:0] LATCH_RST = 5'h00;
  localparam logic [PORT_W-1:0] DIR_RST = 5'h1f;
  localparam logic [1:0] ANA_CFG_RST = 2'h0;

  // ----------------------------------------------------------------
  // Analog configuration codes and bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] CFG_ALL_ANALOG = 2'h0;
  localparam logic [1:0] CFG_REF_ON_PIN3 = 2'h1;
  localparam logic [1:0] CFG_TWO_ANALOG = 2'h2;
  localparam logic [1:0] CFG_ALL_DIGITAL = 2'h3;
  localparam logic [ANA_W-1:0] MASK_ALL = 4'hf;
  localparam logic [ANA_W-1:0] MASK_TWO = 4'h3;
  localparam logic [ANA_W-1:0] MASK_NONE = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Returns which analog-capable pins are in analog use for a configuration code.
  function automatic logic [ANA_W-1:0] analog_mask(input logic [1:0] cfg);
    case (cfg)
      CFG_ALL_ANALOG: analog_mask = MASK_ALL;
      CFG_REF_ON_PIN3: analog_mask = MASK_ALL;
      CFG_TWO_ANALOG: analog_mask = MASK_TWO;
      default: analog_mask = MASK_NONE;
    endcase
  endfunction : analog_mask

endpackage : fpp_pkg

// file: src/fpp_pin_sync.sv
// Two-flop synchroniser for the port pin inputs.
`timescale 1ns/100ps
`default_nettype none
module fpp_pin_sync #(
  parameter int WIDTH = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Refuses a width that leaves nothing to synchronise.
  if (WIDTH < 1) begin : g_bad_width
    $error("fpp_pin_sync: WIDTH must be at least 1");
  end

  // First stage is read only by the second stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : fpp_pin_sync
`default_nettype wire

// file: src/fpp_port.sv
// Five pin general purpose port with analog pin sharing, reached over AXI4-Lite.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module fpp_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [fpp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [fpp_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [fpp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [fpp_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [fpp_pkg::PORT_W-1:0] port_pin_in,
  output logic [fpp_pkg::PORT_W-1:0] port_pin_out,
  output logic [fpp_pkg::PORT_W-1:0] port_pin_oe_n,
  output logic timer_zero_clk_in,
  output logic [fpp_pkg::ANA_W-1:0] analog_chan_en,
  output logic analog_ref_en
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [fpp_pkg::PORT_W-1:0] latch_reg, pin_direction_bits_reg, pin_sync, port_read;
  logic [fpp_pkg::PORT_W-1:0] pin_out_reg, pin_oe_n_reg;
  logic [1:0] analog_pin_config_reg, s_axi_bresp_reg, s_axi_rresp_reg;
  logic [fpp_pkg::ANA_W-1:0] ana_mask, analog_chan_en_reg;
  logic [fpp_pkg::ADDR_W-1:0] aw_addr_reg;
  logic [fpp_pkg::DATA_W-1:0] w_data_reg, rd_next, s_axi_rdata_reg;
  logic w_strb0_reg, wr_fire, rd_hit, timer_clk_reg, analog_ref_en_reg;
  logic s_axi_awready_reg, s_axi_wready_reg, s_axi_bvalid_reg, s_axi_arready_reg, s_axi_rvalid_reg;

  // Tells whether an address names one of the three registers.
  function automatic logic addr_hit(input logic [fpp_pkg::ADDR_W-1:0] a);
    addr_hit = (a == fpp_pkg::PORT_DATA_ADDR) || (a == fpp_pkg::PIN_DIR_ADDR) ||
               (a == fpp_pkg::ANA_CFG_ADDR);
  endfunction : addr_hit

  // ----------------------------------------------------------------
  // Pin input path
  // ----------------------------------------------------------------
  // Pins are asynchronous, so they pass two flops before use.
  fpp_pin_sync #(
    .WIDTH(fpp_pkg::PORT_W)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(port_pin_in),
    .sync_out(pin_sync)
  );

  // Analog pins have the digital input gated off and read as zero.
  // digital input disable
  assign ana_mask = fpp_pkg::analog_mask(analog_pin_config_reg);
  assign port_read = pin_sync & ~{1'b0, ana_mask};

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  assign wr_fire = !s_axi_awready_reg && !s_axi_wready_reg && !s_axi_bvalid_reg;

  // Address is held from its handshake until the response is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready_reg <= 1'b1;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready_reg) begin
      s_axi_awready_reg <= 1'b0;
      aw_addr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid_reg && s_axi_bready) begin
      s_axi_awready_reg <= 1'b1;
    end
  end

  // Data is held from its handshake until the response is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready_reg <= 1'b1;
      w_data_reg <= '0;
      w_strb0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready_reg) begin
      s_axi_wready_reg <= 1'b0;
      w_data_reg <= s_axi_wdata;
      w_strb0_reg <= s_axi_wstrb[0];
    end else if (s_axi_bvalid_reg && s_axi_bready) begin
      s_axi_wready_reg <= 1'b1;
    end
  end

  // Response is raised one cycle after both halves are held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid_reg <= 1'b0;
      s_axi_bresp_reg <= fpp_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_reg <= 1'b1;
      s_axi_bresp_reg <= addr_hit(aw_addr_reg) ? fpp_pkg::RESP_OKAY : fpp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Port writes sample the pins, merge the written lane and store the latch.
  // five-bit data latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= fpp_pkg::LATCH_RST;
    end else if (wr_fire && aw_addr_reg == fpp_pkg::PORT_DATA_ADDR) begin
      latch_reg <= w_strb0_reg ? w_data_reg[fpp_pkg::PORT_W-1:0] : port_read;
    end
  end

  // Direction and analog configuration take only their implemented low bits.
  // analog after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_direction_bits_reg <= fpp_pkg::DIR_RST;
      analog_pin_config_reg <= fpp_pkg::ANA_CFG_RST;
    end else if (wr_fire && w_strb0_reg) begin
      if (aw_addr_reg == fpp_pkg::PIN_DIR_ADDR) begin
        pin_direction_bits_reg <= w_data_reg[fpp_pkg::PORT_W-1:0];
      end
      if (aw_addr_reg == fpp_pkg::ANA_CFG_ADDR) begin
        analog_pin_config_reg <= w_data_reg[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // Selects the read value; pins for data, zero above the fields.
  // data read returns pins
  always_comb begin
    rd_next = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      fpp_pkg::PORT_DATA_ADDR: rd_next[fpp_pkg::PORT_W-1:0] = port_read;
      fpp_pkg::PIN_DIR_ADDR: rd_next[fpp_pkg::PORT_W-1:0] = pin_direction_bits_reg;
      fpp_pkg::ANA_CFG_ADDR: rd_next[1:0] = analog_pin_config_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // One read in flight; data appears the cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready_reg <= 1'b1;
      s_axi_rvalid_reg <= 1'b0;
      s_axi_rdata_reg <= '0;
      s_axi_rresp_reg <= fpp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready_reg) begin
      s_axi_arready_reg <= 1'b0;
      s_axi_rvalid_reg <= 1'b1;
      s_axi_rdata_reg <= rd_next;
      s_axi_rresp_reg <= rd_hit ? fpp_pkg::RESP_OKAY : fpp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_reg && s_axi_rready) begin
      s_axi_arready_reg <= 1'b1;
      s_axi_rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers and shared functions
  // ----------------------------------------------------------------
  // Push-pull pins follow the latch when direction is zero.
  // high-Z on input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_reg <= '0;
      pin_oe_n_reg <= '1;
    end else begin
      pin_out_reg[fpp_pkg::ANA_W-1:0] <= latch_reg[fpp_pkg::ANA_W-1:0];
      pin_oe_n_reg[fpp_pkg::ANA_W-1:0] <= pin_direction_bits_reg[fpp_pkg::ANA_W-1:0];
      pin_out_reg[fpp_pkg::TIMER_PIN] <= 1'b0;
      pin_oe_n_reg[fpp_pkg::TIMER_PIN] <= pin_direction_bits_reg[fpp_pkg::TIMER_PIN] ||
                                         latch_reg[fpp_pkg::TIMER_PIN];
    end
  end

  // Timer clock and analog selects are registered copies of their sources.
  // timer clock tap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_clk_reg <= 1'b0;
      analog_chan_en_reg <= fpp_pkg::analog_mask(fpp_pkg::ANA_CFG_RST);
      analog_ref_en_reg <= 1'b0;
    end else begin
      timer_clk_reg <= pin_sync[fpp_pkg::TIMER_PIN];
      analog_chan_en_reg <= ana_mask;
      analog_ref_en_reg <= (analog_pin_config_reg == fpp_pkg::CFG_REF_ON_PIN3);
    end
  end

  assign s_axi_awready = s_axi_awready_reg;
  assign s_axi_wready = s_axi_wready_reg;
  assign s_axi_bvalid = s_axi_bvalid_reg;
  assign s_axi_bresp = s_axi_bresp_reg;
  assign s_axi_arready = s_axi_arready_reg;
  assign s_axi_rvalid = s_axi_rvalid_reg;
  assign s_axi_rdata = s_axi_rdata_reg;
  assign s_axi_rresp = s_axi_rresp_reg;
  assign port_pin_out = pin_out_reg;
  assign port_pin_oe_n = pin_oe_n_reg;
  assign timer_zero_clk_in = timer_clk_reg;
  assign analog_chan_en = analog_chan_en_reg;
  assign analog_ref_en = analog_ref_en_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_LATCH_STORE: assert property (wr_fire && aw_addr_reg == fpp_pkg::PORT_DATA_ADDR && w_strb0_reg
    |=> latch_reg == $past(w_data_reg[fpp_pkg::PORT_W-1:0]))
    else $error("Port write did not reach the latch.");
  AST_INPUT_HIGHZ: assert property (pin_direction_bits_reg != 5'h00 && $stable(pin_direction_bits_reg)
    |=> (pin_oe_n_reg & $past(pin_direction_bits_reg)) == $past(pin_direction_bits_reg))
    else $error("Input pin still driven.");
  AST_DRIVE_LATCH: assert property (##1 (pin_oe_n_reg[3:0] == ~$past(~pin_direction_bits_reg[3:0]))
    && (pin_out_reg[3:0] == $past(latch_reg[3:0])))
    else $error("Push-pull pin does not follow latch.");
  AST_READ_PINS: assert property (s_axi_arvalid && s_axi_arready_reg &&
    s_axi_araddr == fpp_pkg::PORT_DATA_ADDR |=> s_axi_rvalid && s_axi_rdata[4:0] == $past(port_read))
    else $error("Port read did not return pin levels.");
  AST_RMW_KEEP: assert property (wr_fire && aw_addr_reg == fpp_pkg::PORT_DATA_ADDR && !w_strb0_reg
    |=> latch_reg == $past(port_read))
    else $error("Unwritten lane did not store sampled pins.");
  AST_OPEN_DRAIN: assert property (pin_out_reg[4] == 1'b0 &&
    (pin_oe_n_reg[4] || $past(!latch_reg[4] && !pin_direction_bits_reg[4])))
    else $error("Timer pin drove high or drove when it should not.");
  AST_TIMER_TAP: assert property (##1 timer_zero_clk_in == $past(pin_sync[4]))
    else $error("Timer clock does not follow pin.");
  AST_ANALOG_SEL: assert property (##1 analog_chan_en == $past(ana_mask) &&
    analog_ref_en == ($past(analog_pin_config_reg) == fpp_pkg::CFG_REF_ON_PIN3))
    else $error("Analog selection does not match configuration.");
  AST_RESET_ANALOG: assert property ($rose(aresetn) |-> analog_pin_config_reg == fpp_pkg::ANA_CFG_RST
    && pin_direction_bits_reg == fpp_pkg::DIR_RST && analog_chan_en == 4'hf)
    else $error("Reset did not leave pins analog inputs.");
  AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0)
    else $error("Unimplemented bits read nonzero.");
  AST_ANALOG_ZERO: assert property (s_axi_arvalid && s_axi_arready_reg &&
    s_axi_araddr == fpp_pkg::PORT_DATA_ADDR |=> (s_axi_rdata[3:0] & $past(ana_mask)) == 4'h0)
    else $error("Analog pin read nonzero.");
  AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write response dropped early.");

  COV_PORT_WRITE: cover property (wr_fire && aw_addr_reg == fpp_pkg::PORT_DATA_ADDR);
  COV_REF_MODE: cover property (analog_ref_en);
  COV_OD_PULL: cover property (!pin_oe_n_reg[4]);
  COV_UNMAPPED: cover property (s_axi_rvalid && s_axi_rresp == fpp_pkg::RESP_SLVERR);

endmodule : fpp_port
`default_nettype wire

// file: test/fpp_pin_model.sv
// Board model of the circuitry attached to the five port pins.
`timescale 1ns/100ps
`default_nettype none
module fpp_pin_model (
  input wire logic [fpp_pkg::PORT_W-1:0] pin_out,
  input wire logic [fpp_pkg::PORT_W-1:0] pin_oe_n,
  input wire logic [fpp_pkg::PORT_W-1:0] ext_val,
  input wire logic [fpp_pkg::PORT_W-1:0] ext_en,
  output logic [fpp_pkg::PORT_W-1:0] pin_level
);
  // Each pin takes the device driver first, then an outside driver, else the board pull-up.
  // The timer pin driver can only sink, so an enabled driver there always reads low.
  always_comb begin
    for (int i = 0; i < fpp_pkg::PORT_W; i++) begin
      if (pin_oe_n[i] == 1'b0) begin
        pin_level[i] = (i == fpp_pkg::TIMER_PIN) ? 1'b0 : pin_out[i];
      end else if (ext_en[i] == 1'b1) begin
        pin_level[i] = ext_val[i];
      end else begin
        pin_level[i] = 1'b1;
      end
    end
  end
endmodule : fpp_pin_model
`default_nettype wire

// file: test/test_five_pin_port_with_analog_mux.sv
// Self-checking testbench for the five pin port with analog pin sharing.
`timescale 1ns/100ps
`default_nettype none
module test_five_pin_port_with_analog_mux;
  typedef struct packed {
    logic [1:0] cfg;
    logic [4:0] dir, lat, ext, rd, oe;
    logic [3:0] ana;
    logic rf;
  } fpp_row_t;
  // Columns: config, direction, latch, outside drive, expected read, oe_n, analog enables, reference.
  localparam fpp_row_t ROWS [6] = '{
    '{2'h3, 5'h00, 5'h15, 5'h00, 5'h15, 5'h10, 4'h0, 1'b0},
    '{2'h3, 5'h00, 5'h0a, 5'h00, 5'h0a, 5'h00, 4'h0, 1'b0},
    '{2'h3, 5'h1f, 5'h00, 5'h13, 5'h13, 5'h1f, 4'h0, 1'b0},
    '{2'h0, 5'h1f, 5'h00, 5'h1f, 5'h10, 5'h1f, 4'hf, 1'b0},
    '{2'h1, 5'h1f, 5'h00, 5'h1f, 5'h10, 5'h1f, 4'hf, 1'b1},
    '{2'h2, 5'h1f, 5'h00, 5'h0f, 5'h0c, 5'h1f, 4'h3, 1'b0}};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0] pin_in, pin_out, pin_oe_n, ext_val = 5'h1f, ext_en = 5'h1f;
  logic timer_clk;
  logic [3:0] ana_en;
  logic ref_en;
  int err_total = 0, samples_checked = 0;

  // Clock at 20 MHz.
  always #25 aclk = ~aclk;

  fpp_port fpp_port_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe_n(pin_oe_n),
    .timer_zero_clk_in(timer_clk), .analog_chan_en(ana_en), .analog_ref_en(ref_en));

  fpp_pin_model fpp_pin_model_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
    .ext_en(ext_en), .pin_level(pin_in));

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      err_total++;
    end
  endtask : chk

  // One AXI4-Lite write; address and data are held until each is taken.
  // It waits as long as the answer takes; only the watchdog ends a hung wait.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw_done, w_done, b_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    b_done = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_done) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (aw_done && w_done && s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        b_done = 1'b1;
      end
    end
  endtask : axi_write

  // One AXI4-Lite read; the address is held until it is taken.
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic r_done;
    r_done = 1'b0;
    d = 32'h0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_done) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        r_done = 1'b1;
      end
    end
  endtask : axi_read

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_read(fpp_pkg::PIN_DIR_ADDR, rd, rsp);
    chk(rd, 32'h1f, "direction reset");
    axi_read(fpp_pkg::ANA_CFG_ADDR, rd, rsp);
    chk(rd, 32'h0, "config reset");
    axi_read(fpp_pkg::PORT_DATA_ADDR, rd, rsp);
    chk(rd, 32'h10, "analog pins read zero");
    chk(32'(ana_en), 32'hf, "analog enables at reset");
    ext_val <= 5'h0f;
    repeat (5) @(posedge aclk);
    chk(32'(timer_clk), 32'h0, "timer clock low");
    ext_val <= 5'h1f;
    repeat (5) @(posedge aclk);
    chk(32'(timer_clk), 32'h1, "timer clock high");
    for (int k = 0; k < 6; k++) begin
      ext_en <= ROWS[k].dir;
      ext_val <= ROWS[k].ext;
      axi_write(fpp_pkg::ANA_CFG_ADDR, 32'(ROWS[k].cfg), 4'h1, rsp);
      axi_write(fpp_pkg::PIN_DIR_ADDR, 32'(ROWS[k].dir), 4'h1, rsp);
      axi_write(fpp_pkg::PORT_DATA_ADDR, 32'(ROWS[k].lat), 4'h1, rsp);
      chk(32'(rsp), 32'(fpp_pkg::RESP_OKAY), "write response");
      repeat (4) @(posedge aclk);
      axi_read(fpp_pkg::PORT_DATA_ADDR, rd, rsp);
      chk(rd, 32'(ROWS[k].rd), "pin levels read");
      chk(32'(pin_oe_n), 32'(ROWS[k].oe), "output enables");
      chk(32'(ana_en), 32'(ROWS[k].ana), "analog enables");
      chk(32'(ref_en), 32'(ROWS[k].rf), "reference enable");
    end
    // upper bits ignored
    // Pins one and zero are still analog here, but their direction bits take the written value like the others.
    axi_write(fpp_pkg::PIN_DIR_ADDR, 32'hfffffff7, 4'hf, rsp);
    axi_read(fpp_pkg::PIN_DIR_ADDR, rd, rsp);
    chk(rd, 32'h17, "upper bits read zero");
    axi_write(fpp_pkg::ANA_CFG_ADDR, 32'(fpp_pkg::CFG_ALL_DIGITAL), 4'h1, rsp);
    axi_write(fpp_pkg::PIN_DIR_ADDR, 32'h1f, 4'h1, rsp);
    ext_en <= 5'h1f;
    ext_val <= 5'h06;
    repeat (4) @(posedge aclk);
    axi_write(fpp_pkg::PORT_DATA_ADDR, 32'h1f, 4'h0, rsp);
    ext_en <= 5'h00;
    axi_write(fpp_pkg::PIN_DIR_ADDR, 32'h00, 4'h1, rsp);
    repeat (4) @(posedge aclk);
    axi_read(fpp_pkg::PORT_DATA_ADDR, rd, rsp);
    chk(rd, 32'h06, "latch holds sampled pins");
    // Unmapped address refused
    axi_write(12'h100, 32'h1, 4'hf, rsp);
    chk(32'(rsp), 32'(fpp_pkg::RESP_SLVERR), "unmapped write response");
    axi_read(12'h100, rd, rsp);
    chk(32'(rsp), 32'(fpp_pkg::RESP_SLVERR), "unmapped read response");
    chk(rd, 32'h0, "unmapped read data");
    // defaults return after a reset in mid-run
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(32'(pin_oe_n), 32'h1f, "pins released after reset");
    chk(32'(ana_en), 32'hf, "analog enables after reset");
    axi_read(fpp_pkg::ANA_CFG_ADDR, rd, rsp);
    chk(rd, 32'h0, "config after reset");
    axi_read(fpp_pkg::PORT_DATA_ADDR, rd, rsp);
    chk(rd, 32'h10, "analog pins read zero after reset");
    give_verdict();
  end
endmodule : test_five_pin_port_with_analog_mux
`default_nettype wire
